//--- core/serial_rx_params.svh
// Purpose: Named constants for the serial receive path
// Assumes: Included by bare name from the core files
// Notes: Offsets are register indices on the plain register port
`ifndef SERIAL_RX_PARAMS_SVH
`define SERIAL_RX_PARAMS_SVH

`define REG_ADDR_W 3
`define OFS_RX_STATUS_CONTROL 3'h0
`define OFS_TX_STATUS_CONTROL 3'h1
`define OFS_BAUD_CONTROL 3'h2
`define OFS_BAUD_DIVISOR_HIGH 3'h3
`define OFS_BAUD_DIVISOR_LOW 3'h4
`define OFS_RX_BUFFER 3'h5

// rx_status_control bit positions
`define RCS_SERIAL_PORT_ENABLE 7
`define RCS_NINTH_BIT_RX_ENABLE 6
`define RCS_SINGLE_RECEIVE_ENABLE 5
`define RCS_CONTINUOUS_RECEIVE_ENABLE 4
`define RCS_ADDRESS_DETECT_ENABLE 3
`define RCS_FRAMING_ERROR_FLAG 2
`define RCS_OVERRUN_ERROR_FLAG 1
`define RCS_RECEIVED_NINTH_BIT 0
`define RCS_WR_MASK 8'hF8

// tx_status_control bit positions
`define TXS_SYNC_SELECT 4
`define TXS_HIGH_SPEED_BAUD_SELECT 2
`define TXS_WR_MASK 8'hFD
`define TXS_SHIFT_EMPTY 8'h02

// baud_control bit positions
`define BDC_RX_IDLE 6
`define BDC_RX_POLARITY_INVERT 5
`define BDC_WIDE_DIVISOR_SELECT 3
`define BDC_WR_MASK 8'hBB

`define RST_RX_STATUS_CONTROL 8'h00
`define RST_TX_STATUS_CONTROL 8'h00
`define RST_BAUD_CONTROL 8'h00
`define RST_BAUD_DIVISOR 16'h0000

`define TICK_HALF_BIT 4'h7
`define TICK_LAST 4'hF
`define X64_PRESCALE_LAST 2'h3
`define BIT_IDX_8TH 4'h7
`define BIT_IDX_9TH 4'h8

`endif

//--- core/serial_rx_pkg.sv
// Purpose: Types shared by the serial receive path
// Assumes: Constants live in serial_rx_params.svh
// Notes: Nothing here is imported; use package::name
package serial_rx_pkg;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } rx_state_t;

  typedef struct packed {
    logic framing_error;
    logic ninth;
    logic [7:0] data;
  } rx_char_t;

endpackage

//--- core/baud_gen.sv
// Purpose: Baud generator producing a x16 oversample tick
// Assumes: Divisor stable while running
// Notes: Slow mode divides by four more so the line is seen at x64
`include "serial_rx_params.svh"

module baud_gen (
  input wire logic clk_sys, // System clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic run, // Generator enable
  input wire logic [15:0] divisor, // Divisor high:low
  input wire logic wide_divisor_select, // Use all 16 divisor bits
  input wire logic high_speed_baud_select, // High-speed option
  output logic sample_tick // One pulse per 1/16 bit
);

  logic [15:0] cnt_q;
  logic [1:0] pre_q;
  logic brg_tick;
  logic x64_mode;
  logic [15:0] reload;

  assign reload = wide_divisor_select ? divisor : {8'h00, divisor[7:0]};
  assign x64_mode = !wide_divisor_select && !high_speed_baud_select;
  assign brg_tick = run && (cnt_q == 16'h0000);
  assign sample_tick = brg_tick && (!x64_mode ||
                       (pre_q == `X64_PRESCALE_LAST));

  always_ff @(posedge clk_sys) begin
    if (sys_rst || !run) begin
      cnt_q <= 16'h0000;
      pre_q <= 2'h0;
    end else if (brg_tick) begin
      cnt_q <= reload;
      pre_q <= pre_q + 2'h1;
    end else begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

endmodule

//--- core/rx_fifo.sv
// Purpose: Small first-in first-out store for received characters
// Assumes: DEPTH a power of two, at least two
// Notes: Push and pop may share a cycle; full refuses the push
module rx_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys, // System clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic in_valid, // Push request
  output logic in_ready, // Room for a push
  input wire logic [WIDTH-1:0] in_data, // Pushed entry
  output logic out_valid, // Head entry present
  input wire logic out_ready, // Pop request
  output logic [WIDTH-1:0] out_data // Head entry
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("rx_fifo DEPTH must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != CW'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_ready && out_valid;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_q + PW'(push);
      rd_ptr_q <= rd_ptr_q + PW'(pop);
      count_q <= count_q + CW'(push) - CW'(pop);
    end
  end

endmodule

//--- core/async_serial_receiver.sv
// Purpose: Asynchronous receive path with oversampling and FIFO
// Assumes: rx_line and register strobes synchronous to clk_sys
// Notes: Transmitter, auto-baud, wake-up and sync modes are absent
//
// Functional notes
// - Recover bits at x16, shift once per bit
// - Start on falling edge of zero start bit
// - Shift 8 or 9 data bits, LSb first
// - Stop bit zero sets framing error, else clears
// - Completed character moves into two-entry FIFO
// - Buffer read pops; flag clears when empty
// - Third character while full: discard, set overrun
// - Overrun blocks reception until enable toggled
// - Flag on data; interrupt only when enabled
// - Address detect cleared: every character is stored
// - Shift register never visible to software
// - Unimplemented register bits read as zero
// - Sampling clock x16 or x64 per options
//
// The strobed register port and the register offsets are this design's own decisions.
`include "serial_rx_params.svh"

module async_serial_receiver #(
  parameter int FIFO_DEPTH = 2
) (
  input wire logic clk_sys, // System clock, 50 MHz
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic [`REG_ADDR_W-1:0] reg_addr, // Register index
  input wire logic [7:0] reg_wr_data, // Write data
  input wire logic reg_wr_en, // Write strobe
  input wire logic reg_rd_en, // Read strobe
  output logic [7:0] reg_rd_data, // Read data, cycle after strobe
  input wire logic rx_line, // Serial receive pin
  input wire logic rx_irq_enable, // Receive interrupt enable
  output logic rx_ready_flag, // Character waiting
  output logic rx_irq // Receive interrupt request
);

  generate
    if (FIFO_DEPTH < 2) begin : g_bad_depth
      $error("FIFO_DEPTH must be at least 2");
    end
  endgenerate

  // Software-visible control state
  logic [7:0] rx_ctrl_q;
  logic [7:0] tx_ctrl_q;
  logic [7:0] baud_ctrl_q;
  logic [15:0] divisor_q;
  logic overrun_q;
  logic [7:0] rd_data_q;

  // Receive engine state
  serial_rx_pkg::rx_state_t state_q;
  logic [3:0] tick_q;
  logic [3:0] bit_idx_q;
  logic [8:0] rx_shift_register_q;
  logic [2:0] recov_q;
  logic line_prev_q;

  // Decoded controls
  logic serial_port_enable;
  logic ninth_bit_rx_enable;
  logic continuous_receive_enable;
  logic address_detect_enable;
  logic rx_polarity_invert;
  logic wide_divisor_select;
  logic high_speed_baud_select;
  logic rx_on;
  logic sample_tick;
  logic line_in;
  logic bit_val;
  logic start_edge;
  logic stop_done;
  logic keep_char;
  logic push_valid;
  logic push_ready;
  logic [3:0] last_idx;
  serial_rx_pkg::rx_char_t push_char;
  serial_rx_pkg::rx_char_t head_char;
  logic head_valid;
  logic pop;

  // Register decode
  logic sel_rx_ctrl;
  logic sel_tx_ctrl;
  logic sel_baud_ctrl;
  logic sel_div_high;
  logic sel_div_low;
  logic sel_rx_buffer;
  logic [7:0] rx_ctrl_view;
  logic [7:0] baud_ctrl_view;
  logic [7:0] rd_mux;

  assign sel_rx_ctrl = (reg_addr == `OFS_RX_STATUS_CONTROL);
  assign sel_tx_ctrl = (reg_addr == `OFS_TX_STATUS_CONTROL);
  assign sel_baud_ctrl = (reg_addr == `OFS_BAUD_CONTROL);
  assign sel_div_high = (reg_addr == `OFS_BAUD_DIVISOR_HIGH);
  assign sel_div_low = (reg_addr == `OFS_BAUD_DIVISOR_LOW);
  assign sel_rx_buffer = (reg_addr == `OFS_RX_BUFFER);

  assign serial_port_enable = rx_ctrl_q[`RCS_SERIAL_PORT_ENABLE];
  assign ninth_bit_rx_enable = rx_ctrl_q[`RCS_NINTH_BIT_RX_ENABLE];
  assign continuous_receive_enable =
    rx_ctrl_q[`RCS_CONTINUOUS_RECEIVE_ENABLE];
  assign address_detect_enable = rx_ctrl_q[`RCS_ADDRESS_DETECT_ENABLE];
  assign rx_polarity_invert = baud_ctrl_q[`BDC_RX_POLARITY_INVERT];
  assign wide_divisor_select = baud_ctrl_q[`BDC_WIDE_DIVISOR_SELECT];
  assign high_speed_baud_select = tx_ctrl_q[`TXS_HIGH_SPEED_BAUD_SELECT];

  // Sync select is left to software; port enable, continuous receive enable and no overrun gate here
  assign rx_on = serial_port_enable && continuous_receive_enable &&
                 !overrun_q;

  baud_gen u_baud_gen (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .run(rx_on),
    .divisor(divisor_q),
    .wide_divisor_select(wide_divisor_select),
    .high_speed_baud_select(high_speed_baud_select),
    .sample_tick(sample_tick)
  );

  // Line after polarity, then a 3-sample recovery shifter
  assign line_in = rx_line ^ rx_polarity_invert;
  assign bit_val = (recov_q[0] & recov_q[1]) | (recov_q[0] & recov_q[2]) |
                   (recov_q[1] & recov_q[2]);
  assign start_edge = line_prev_q && !line_in;
  assign last_idx = ninth_bit_rx_enable ? `BIT_IDX_9TH
                                        : `BIT_IDX_8TH;
  assign stop_done = (state_q == serial_rx_pkg::RX_STOP) && sample_tick &&
                     (tick_q == `TICK_LAST);

  // With nine bits enabled, address detect drops data characters until software clears it
  assign keep_char = !(address_detect_enable && ninth_bit_rx_enable &&
                       !rx_shift_register_q[8]);
  assign push_valid = stop_done && keep_char;
  assign push_char.framing_error = !bit_val;
  assign push_char.ninth = ninth_bit_rx_enable && rx_shift_register_q[8];
  assign push_char.data = ninth_bit_rx_enable ? rx_shift_register_q[7:0]
                                              : rx_shift_register_q[8:1];

  rx_fifo #(
    .WIDTH($bits(serial_rx_pkg::rx_char_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_char),
    .out_valid(head_valid),
    .out_ready(pop),
    .out_data(head_char)
  );

  assign pop = reg_rd_en && sel_rx_buffer;
  assign rx_ready_flag = head_valid;
  assign rx_irq = head_valid && rx_irq_enable;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      line_prev_q <= 1'b0;
      recov_q <= 3'h0;
    end else begin
      line_prev_q <= line_in;
      if (sample_tick) begin
        recov_q <= {recov_q[1:0], line_in};
      end
    end
  end

  // Receive engine: shifts once per bit, sampled at x16
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !rx_on) begin
      state_q <= serial_rx_pkg::RX_IDLE;
      tick_q <= 4'h0;
      bit_idx_q <= 4'h0;
      rx_shift_register_q <= 9'h000;
    end else begin
      case (state_q)
        serial_rx_pkg::RX_IDLE: begin
          tick_q <= 4'h0;
          if (start_edge) begin
            state_q <= serial_rx_pkg::RX_START;
          end
        end
        serial_rx_pkg::RX_START: begin
          if (sample_tick) begin
            tick_q <= tick_q + 4'h1;
            if (tick_q == `TICK_HALF_BIT) begin
              tick_q <= 4'h0;
              bit_idx_q <= 4'h0;
              // A glitch shorter than half a bit is not a start
              if (bit_val) begin
                state_q <= serial_rx_pkg::RX_IDLE;
              end else begin
                state_q <= serial_rx_pkg::RX_DATA;
              end
            end
          end
        end
        serial_rx_pkg::RX_DATA: begin
          if (sample_tick) begin
            tick_q <= tick_q + 4'h1;
            if (tick_q == `TICK_LAST) begin
              rx_shift_register_q <= {bit_val,
                                      rx_shift_register_q[8:1]};
              bit_idx_q <= bit_idx_q + 4'h1;
              if (bit_idx_q == last_idx) begin
                state_q <= serial_rx_pkg::RX_STOP;
              end
            end
          end
        end
        serial_rx_pkg::RX_STOP: begin
          if (sample_tick) begin
            tick_q <= tick_q + 4'h1;
            if (tick_q == `TICK_LAST) begin
              state_q <= serial_rx_pkg::RX_IDLE;
            end
          end
        end
        default: begin
          state_q <= serial_rx_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Set wins; the clear only happens with reception switched off
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      overrun_q <= 1'b0;
    end else if (push_valid && !push_ready) begin
      overrun_q <= 1'b1;
    end else if (!continuous_receive_enable) begin
      overrun_q <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_ctrl_q <= `RST_RX_STATUS_CONTROL;
      tx_ctrl_q <= `RST_TX_STATUS_CONTROL;
      baud_ctrl_q <= `RST_BAUD_CONTROL;
      divisor_q <= `RST_BAUD_DIVISOR;
    end else if (reg_wr_en) begin
      if (sel_rx_ctrl) begin
        rx_ctrl_q <= reg_wr_data & `RCS_WR_MASK;
      end else if (sel_tx_ctrl) begin
        tx_ctrl_q <= reg_wr_data & `TXS_WR_MASK;
      end else if (sel_baud_ctrl) begin
        baud_ctrl_q <= reg_wr_data & `BDC_WR_MASK;
      end else if (sel_div_high) begin
        divisor_q[15:8] <= reg_wr_data;
      end else if (sel_div_low) begin
        divisor_q[7:0] <= reg_wr_data;
      end
    end
  end

  // Framing error and ninth bit describe the character at the FIFO head
  always_comb begin
    rx_ctrl_view = rx_ctrl_q & `RCS_WR_MASK;
    rx_ctrl_view[`RCS_FRAMING_ERROR_FLAG] =
      head_valid && head_char.framing_error;
    rx_ctrl_view[`RCS_OVERRUN_ERROR_FLAG] = overrun_q;
    rx_ctrl_view[`RCS_RECEIVED_NINTH_BIT] = head_valid && head_char.ninth;
    baud_ctrl_view = baud_ctrl_q & `BDC_WR_MASK;
    baud_ctrl_view[`BDC_RX_IDLE] = (state_q == serial_rx_pkg::RX_IDLE);
  end

  // Only the FIFO head is readable, never the shift register
  always_comb begin
    if (sel_rx_ctrl) begin
      rd_mux = rx_ctrl_view;
    end else if (sel_tx_ctrl) begin
      rd_mux = tx_ctrl_q | `TXS_SHIFT_EMPTY;
    end else if (sel_baud_ctrl) begin
      rd_mux = baud_ctrl_view;
    end else if (sel_div_high) begin
      rd_mux = divisor_q[15:8];
    end else if (sel_div_low) begin
      rd_mux = divisor_q[7:0];
    end else if (sel_rx_buffer) begin
      rd_mux = head_valid ? head_char.data : 8'h00;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // Read data stands for one cycle only
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !reg_rd_en) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= rd_mux;
    end
  end

  assign reg_rd_data = rd_data_q;

endmodule

//--- tb/async_serial_receiver_properties.sv
// Purpose: Port-level checks for the serial receive path
// Assumes: One clock domain, synchronous active-high reset
// Notes: Attached to every receiver instance by the bind below
module async_serial_receiver_properties (
  input wire logic clk_sys, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic [2:0] reg_addr, // Register index
  input wire logic [7:0] reg_wr_data, // Write data
  input wire logic reg_wr_en, // Write strobe
  input wire logic reg_rd_en, // Read strobe
  input wire logic [7:0] reg_rd_data, // Read data
  input wire logic rx_line, // Serial line
  input wire logic rx_irq_enable, // Interrupt enable
  input wire logic rx_ready_flag, // Character waiting
  input wire logic rx_irq // Interrupt request
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  irq_follows_flag_a: assert property (
    rx_irq == (rx_ready_flag && rx_irq_enable))
    else $error("interrupt request differs from flag and enable");
  flag_fall_read_a: assert property (
    $fell(rx_ready_flag) |-> $past(reg_rd_en) && $past(reg_addr) == 3'h5)
    else $error("ready flag fell without a buffer read");
  flag_holds_a: assert property (
    rx_ready_flag && !(reg_rd_en && reg_addr == 3'h5) |=> rx_ready_flag)
    else $error("ready flag dropped with no read");
  read_idle_zero_a: assert property (
    !reg_rd_en |=> reg_rd_data == 8'h00)
    else $error("read data shown without a read");
  unmapped_zero_a: assert property (
    reg_rd_en && reg_addr > 3'h5 |=> reg_rd_data == 8'h00)
    else $error("unmapped index read nonzero");
  baud_gap_zero_a: assert property (
    reg_rd_en && reg_addr == 3'h2 |=> !reg_rd_data[2])
    else $error("unused baud control bit read as one");
  divisor_back_a: assert property (
    reg_wr_en && (reg_addr == 3'h3 || reg_addr == 3'h4) ##1
    reg_rd_en && reg_addr == $past(reg_addr)
    |=> reg_rd_data == $past(reg_wr_data, 2))
    else $error("divisor byte not read back");
  status_back_a: assert property (
    reg_wr_en && reg_addr == 3'h0 ##1 reg_rd_en && reg_addr == 3'h0
    |=> (reg_rd_data >> 3) == ($past(reg_wr_data, 2) >> 3))
    else $error("control bits not read back");
endmodule

bind async_serial_receiver async_serial_receiver_properties chk_u (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_rd_data(reg_rd_data), .rx_line(rx_line),
  .rx_irq_enable(rx_irq_enable), .rx_ready_flag(rx_ready_flag),
  .rx_irq(rx_irq)
);

//--- tb/serial_tx_model.sv
// Purpose: Remote serial transmitter on the receive line
// Assumes: Bit time given in clocks, one frame per go pulse
// Notes: Line idles high (low when inverted) between frames, whatever the stop level
module serial_tx_model (
  input wire logic clk_sys, // System clock
  input wire logic go, // Start one frame
  input wire logic [8:0] data, // Character, bit 8 sent when nine
  input wire logic nine, // Nine data bits
  input wire logic stop_bit, // Stop level, 0 forces an error
  input wire logic invert, // Line polarity inverted
  input wire logic [6:0] bit_clks, // Clocks per bit
  output logic line, // Serial line to the device
  output logic busy // Frame in progress
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] shift_q = '1;
  logic [3:0] left_q = '0;
  logic [6:0] cnt_q = '0;
  logic busy_q = 1'b0;
  wire last_w = (cnt_q == bit_clks - 7'h01);

  always @(posedge clk_sys) begin
    if (!busy_q && go) begin
      // Start bit low, then data LSb first, then stop
      shift_q <= nine ? {stop_bit, data, 1'b0} :
        {1'b1, stop_bit, data[7:0], 1'b0};
      left_q <= nine ? 4'hB : 4'hA;
      cnt_q <= '0;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      cnt_q <= last_w ? 7'h00 : cnt_q + 7'h01;
      if (last_w) begin
        shift_q <= {1'b1, shift_q[10:1]};
        left_q <= left_q - 4'h1;
        busy_q <= (left_q != 4'h1);
      end
    end
  end
  assign busy = busy_q;
  assign line = (busy_q ? shift_q[0] : 1'b1) ^ invert;
endmodule

//--- tb/async_serial_receiver_tb.sv
// Purpose: Self-checking bench for the serial receive path
// Assumes: Divisor mostly 0, so a bit is 16 clocks, 64 in slow mode
// Notes: Random characters mixed with corner values, fixed seed
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end

module async_serial_receiver_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wr_data = 8'h00;
  logic [7:0] reg_rd_data, cfg, v, d8;
  logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, rx_irq_enable = 1'b0;
  logic go = 1'b0, nine = 1'b0, inv = 1'b0, stop_bit = 1'b1;
  logic rx_line, rx_ready_flag, rx_irq, busy;
  logic [8:0] data = 9'h000;
  logic [6:0] bit_clks = 7'h10;
  int mismatches = 0, checks = 0, cyc = 0;
  logic [7:0] rv [8] = '{8'h00, 8'h02, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00};

  always #10 clk_sys = ~clk_sys;

  async_serial_receiver #(.FIFO_DEPTH(2)) dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .rx_line(rx_line),
    .rx_irq_enable(rx_irq_enable), .rx_ready_flag(rx_ready_flag),
    .rx_irq(rx_irq));
  serial_tx_model tx_u (
    .clk_sys(clk_sys), .go(go), .data(data), .nine(nine),
    .stop_bit(stop_bit), .invert(inv), .bit_clks(bit_clks),
    .line(rx_line), .busy(busy));

  function automatic logic [7:0] exp_st(logic n9, logic fe, logic oe);
    return {cfg[7:3], fe, oe, n9};
  endfunction

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Bus tasks start right after an edge; a write after a write lets an
  // edge pass so the strobe is never driven twice in one time step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    if (reg_wr_en) @(posedge clk_sys);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] r);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    @(negedge clk_sys);
    r = reg_rd_data;
    @(posedge clk_sys);
  endtask

  task automatic cfgw(input logic [7:0] c);
    cfg = c;
    wr(3'h0, c);
    rd(3'h0, v);
    `CHK(v[7:3], c[7:3])
  endtask

  task automatic send(input logic [8:0] d, input logic s);
    int n;
    n = 0;
    data <= d;
    stop_bit <= s;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (busy && n < 2000);
    if (n >= 2000) mismatches++;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic chk_flag(input logic e);
    @(negedge clk_sys);
    `CHK(rx_ready_flag, e)
    @(posedge clk_sys);
  endtask

  // Status first, then the byte, as software is told to do
  task automatic get(input logic [8:0] d, input logic fe, input logic oe);
    @(negedge clk_sys);
    `CHK(rx_ready_flag, 1'b1)
    `CHK(rx_irq, rx_irq_enable)
    @(posedge clk_sys);
    rd(3'h0, v);
    `CHK(v, exp_st(d[8], fe, oe))
    rd(3'h5, v);
    `CHK(v, d[7:0])
  endtask

  // Ceiling well above the few thousand cycles the frames need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict;
    end
  end

  initial begin
    void'($urandom(32'h6016));
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      if (i != 5) begin
        rd(i[2:0], v);
        `CHK(v, rv[i])
      end
    end
    for (int a = 3; a < 7; a++) begin
      d8 = 8'($urandom);
      wr(a[2:0], d8);
      rd(a[2:0], v);
      `CHK(v, (a > 4) ? 8'h00 : d8)
      wr(a[2:0], 8'h00);
    end
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h08);
    cfgw(8'h90);
    d8 = 8'($urandom);
    send({1'b0, d8}, 1'b0);
    get({1'b0, d8}, 1'b1, 1'b0);
    for (int i = 0; i < 6; i++) begin
      d8 = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      rx_irq_enable <= (i < 2) ? i[0] : 1'($urandom);
      send({1'b0, d8}, 1'b1);
      get({1'b0, d8}, 1'b0, 1'b0);
    end
    send(9'h0A5, 1'b1);
    send(9'h05A, 1'b1);
    send(9'h0C3, 1'b1);
    get(9'h0A5, 1'b0, 1'b1);
    get(9'h05A, 1'b0, 1'b1);
    chk_flag(1'b0);
    send(9'h011, 1'b1);
    chk_flag(1'b0);
    cfgw(8'h80);
    cfgw(8'h90);
    send(9'h022, 1'b1);
    get(9'h022, 1'b0, 1'b0);
    nine <= 1'b1;
    cfgw(8'hD0);
    send(9'h1E7, 1'b1);
    get(9'h1E7, 1'b0, 1'b0);
    cfgw(8'hD8);
    send(9'h033, 1'b1);
    chk_flag(1'b0);
    send(9'h1C4, 1'b1);
    get(9'h1C4, 1'b0, 1'b0);
    cfgw(8'hD0);
    send(9'h066, 1'b1);
    get(9'h066, 1'b0, 1'b0);
    nine <= 1'b0;
    // Receiver off while the line polarity flips, or it sees an edge
    cfgw(8'h80);
    wr(3'h2, 8'h28);
    inv <= 1'b1;
    cfgw(8'h90);
    send(9'h0B1, 1'b1);
    get(9'h0B1, 1'b0, 1'b0);
    cfgw(8'h80);
    wr(3'h2, 8'h00);
    inv <= 1'b0;
    bit_clks <= 7'h40;
    cfgw(8'h90);
    send(9'h04E, 1'b1);
    get(9'h04E, 1'b0, 1'b0);
    wr(3'h1, 8'h04);
    bit_clks <= 7'h10;
    send(9'h0D2, 1'b1);
    get(9'h0D2, 1'b0, 1'b0);
    // Nonzero divisor: one tick every two clocks, 32 clocks a bit
    wr(3'h4, 8'h01);
    bit_clks <= 7'h20;
    send(9'h03C, 1'b1);
    get(9'h03C, 1'b0, 1'b0);
    print_verdict;
  end
endmodule
